// [port_e_low_pin_select.sv]
// Port E low-pin function select with interrupt-out control, AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Pin five: GPIO or timer ch1 B
// - Low control bit nine reads zero
// - Pin four: GPIO or timer ch1 A
// - Pin three: GPIO, timer 0D, DMA1 accepted
// - Pin two: GPIO, timer 0C, DMA1 request
// - Pin one: GPIO, timer 0B, DMA0 accepted
// - Pin zero: GPIO, timer 0A, DMA0 request
// - Interrupt-out control acts only when selected
// - Interrupt-out control cleared by power-on only
// - Port D field, 144-pin package only
// - Modes: ack, refresh, mixed, constant high
// - Switching to edge detect catches edge
// - Control registers cleared by power-on only
// - Upper pin interrupt-out, reserved single-chip
module port_e_low_pin_select
  import pin_select_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,             // External power-on reset only
  input wire logic singleChip,        // Operating mode strap, same clock
  input wire logic package144,        // Package option, same clock
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Function sources from the timer, DMA and interrupt controller
  input wire logic [5:0] timerOut,    // Timer compare outputs, pins 0..5
  input wire logic [5:0] timerOe,     // Timer output enables
  input wire logic [5:0] gpioOut,     // Port data outputs
  input wire logic [5:0] gpioOe,      // Port direction
  input wire logic dmaCh0Accepted,    // DMA channel 0 request accepted
  input wire logic dmaCh1Accepted,    // DMA channel 1 request accepted
  input wire intout_src_t intSrc,     // Interrupt-out sources
  // Pins
  input wire logic [5:0] pinIn,       // Raw pin levels, asynchronous
  output logic [5:0] pinOut,
  output logic [5:0] pinOe,
  output logic porteIntOutPin,        // Upper port E interrupt-out level
  output logic portdIntOutPin,        // Port D interrupt-out level
  // To the consumers
  output logic [5:0] pinLevel,        // Synchronised pin levels
  output logic [5:0] timerCapture,    // Pin level routed to timer capture
  output logic dmaCh0Request,         // Edge seen on DMA channel 0 request
  output logic dmaCh1Request,         // Edge seen on DMA channel 1 request
  output pin_fn_t [5:0] pinFunction   // Current function per pin
);

  // Control registers
  logic [15:0] lowCtrl_ff;   // Low-pin function select
  logic [15:0] intOut_ff;    // Interrupt-out control
  logic [15:0] highCtrl_ff;  // Upper pins mode word
  logic [15:0] portdCtrl_ff; // Port D high control copy

  // Write channel holding
  logic awHeld_ff;
  logic wHeld_ff;
  logic [3:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;

  // Pin synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;

  // Apply byte strobes to the low half-word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r & m;
  endfunction

  // Address and data may arrive in either order; both taken before response
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

  // Capture write address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  // Capture write data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_ff == LOW_CTRL_ADDR || awAddr_ff == INTOUT_ADDR ||
          awAddr_ff == HIGH_CTRL_ADDR || awAddr_ff == PORTD_CTRL_ADDR) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only power-on reset clears them, other resets never reach here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lowCtrl_ff <= LOW_CTRL_RST;
      intOut_ff <= INTOUT_RST;
      highCtrl_ff <= HIGH_CTRL_RST;
      portdCtrl_ff <= PORTD_CTRL_RST;
    end else if (doWrite) begin
      if (awAddr_ff == LOW_CTRL_ADDR) begin
        // Reserved bits such as bit 9 are masked off
        lowCtrl_ff <= merge(lowCtrl_ff, wData_ff, wStrb_ff, LOW_CTRL_MASK);
      end else if (awAddr_ff == INTOUT_ADDR) begin
        intOut_ff <= merge(intOut_ff, wData_ff, wStrb_ff, INTOUT_MASK);
      end else if (awAddr_ff == HIGH_CTRL_ADDR) begin
        highCtrl_ff <= merge(highCtrl_ff, wData_ff, wStrb_ff, HIGH_CTRL_MASK);
      end else if (awAddr_ff == PORTD_CTRL_ADDR) begin
        portdCtrl_ff <= merge(portdCtrl_ff, wData_ff, wStrb_ff, PORTD_CTRL_MASK);
      end
    end
  end

  // Read channel: one-cycle answer, held until rready
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == LOW_CTRL_ADDR) begin
        s_axi_rdata <= {16'h0000, lowCtrl_ff};
      end else if (s_axi_araddr == INTOUT_ADDR) begin
        s_axi_rdata <= {16'h0000, intOut_ff};
      end else if (s_axi_araddr == HIGH_CTRL_ADDR) begin
        s_axi_rdata <= {16'h0000, highCtrl_ff};
      end else if (s_axi_araddr == PORTD_CTRL_ADDR) begin
        s_axi_rdata <= {16'h0000, portdCtrl_ff};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two-flop synchroniser for asynchronous pin levels
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
    end
  end

  assign pinLevel = sync2_ff;

  // Function decode per pin
  always_comb begin
    pinFunction[5] = lowCtrl_ff[PIN5_BIT] ? FN_TIMER : FN_GPIO;
    pinFunction[4] = lowCtrl_ff[PIN4_BIT] ? FN_TIMER : FN_GPIO;
    pinFunction[3] = decode2(lowCtrl_ff[PIN3_LSB +: 2], singleChip);
    pinFunction[2] = decode2(lowCtrl_ff[PIN2_LSB +: 2], singleChip);
    pinFunction[1] = decode2(lowCtrl_ff[PIN1_LSB +: 2], singleChip);
    pinFunction[0] = decode2(lowCtrl_ff[PIN0_LSB +: 2], singleChip);
  end

  // Pin drive: DMA accepted outputs on pins 3 and 1, requests are inputs
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pinOut[i] = gpioOut[i];
      pinOe[i] = gpioOe[i];
      timerCapture[i] = 1'b0;
      if (pinFunction[i] == FN_TIMER) begin
        pinOut[i] = timerOut[i];
        pinOe[i] = timerOe[i];
        timerCapture[i] = sync2_ff[i];
      end else if (pinFunction[i] == FN_DMA) begin
        pinOut[i] = 1'b0;
        pinOe[i] = 1'b0;
      end
    end
    if (pinFunction[3] == FN_DMA) begin
      pinOut[3] = dmaCh1Accepted;
      pinOe[3] = 1'b1;
    end
    if (pinFunction[1] == FN_DMA) begin
      pinOut[1] = dmaCh0Accepted;
      pinOe[1] = 1'b1;
    end
  end

  // DMA request edge detectors
  edge_detect u_req0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .active(pinFunction[0] == FN_DMA),
    .level(sync2_ff[0]),
    .edgePulse(dmaCh0Request)
  );

  edge_detect u_req1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .active(pinFunction[2] == FN_DMA),
    .level(sync2_ff[2]),
    .edgePulse(dmaCh1Request)
  );

  // Interrupt-out enables; upper pin reserved in single chip mode, port D needs the 144-pin package
  logic porteIntSel;
  logic portdIntSel;
  assign porteIntSel = (highCtrl_ff[PIN15_LSB +: 2] == 2'b11) && !singleChip;
  assign portdIntSel = (portdCtrl_ff[PORTD_PIN30_LSB +: 2] == 2'b10) && package144;

  // Port E upper pin interrupt-out
  intout_select u_porte_io (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(intOut_ff[PORTE_INTOUT_LSB +: 2]),
    .enable(porteIntSel),
    .src(intSrc),
    .pinOut(porteIntOutPin)
  );

  // Port D pin interrupt-out
  intout_select u_portd_io (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(intOut_ff[PORTD_INTOUT_LSB +: 2]),
    .enable(portdIntSel),
    .src(intSrc),
    .pinOut(portdIntOutPin)
  );

  chk_bit9_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lowCtrl_ff[9])
    else $error("reserved bit 9 set");

  chk_intout_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
    intOut_ff[15:4] == 12'h000)
    else $error("interrupt-out upper bits set");

  chk_pin5_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lowCtrl_ff[PIN5_BIT] |-> pinOut[5] == timerOut[5])
    else $error("pin five not on timer");

  chk_pin4_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lowCtrl_ff[PIN4_BIT] |-> pinOut[4] == gpioOut[4])
    else $error("pin four not on port");

  chk_pin3_dma: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lowCtrl_ff[7:6] == 2'b10 && !singleChip) |-> pinOe[3] && pinOut[3] == dmaCh1Accepted)
    else $error("pin three not dma");

  chk_pin2_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lowCtrl_ff[5:4] == 2'b10 && singleChip) |-> pinFunction[2] == FN_GPIO)
    else $error("pin two not port in single chip");

  chk_pin1_dma: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lowCtrl_ff[3:2] == 2'b10 && !singleChip) |-> pinOut[1] == dmaCh0Accepted)
    else $error("pin one not dma");

  chk_pin0_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lowCtrl_ff[1:0] == 2'b11) |-> pinFunction[0] == FN_GPIO)
    else $error("pin zero reserved not port");

  chk_intout_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !porteIntSel |=> porteIntOutPin)
    else $error("interrupt-out active while deselected");

  chk_req_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(pinFunction[0] == FN_DMA) && sync2_ff[0]) |-> dmaCh0Request)
    else $error("switch edge lost");

  chk_reset_clear: assert property (@(posedge sys_clk)
    !rst_n |=> lowCtrl_ff == LOW_CTRL_RST && intOut_ff == INTOUT_RST)
    else $error("reset did not clear");

endmodule
`default_nettype wire

// [pin_select_pkg.sv]
// Package: register map, field layout, reset values and pin-function codes
package pin_select_pkg;

  // Register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] LOW_CTRL_ADDR = 4'h0;   // Port E low pins control
  localparam logic [3:0] INTOUT_ADDR = 4'h4;     // Interrupt-out control
  localparam logic [3:0] HIGH_CTRL_ADDR = 4'h8;  // Port E upper pins mode word
  localparam logic [3:0] PORTD_CTRL_ADDR = 4'hc; // Port D high control copy

  // Reset values
  localparam logic [15:0] LOW_CTRL_RST = 16'h0000;
  localparam logic [15:0] INTOUT_RST = 16'h0000;
  localparam logic [15:0] HIGH_CTRL_RST = 16'h0000;
  localparam logic [15:0] PORTD_CTRL_RST = 16'h0000;

  // Writable bit masks (reserved bits read zero)
  localparam logic [15:0] LOW_CTRL_MASK = 16'h55ff;
  localparam logic [15:0] INTOUT_MASK = 16'h000f;
  localparam logic [15:0] HIGH_CTRL_MASK = 16'hfd55; // Bits 9, 7, 5, 3, 1 reserved
  localparam logic [15:0] PORTD_CTRL_MASK = 16'hffff;

  // Field positions
  localparam int PIN5_BIT = 10;
  localparam int PIN4_BIT = 8;
  localparam int PIN3_LSB = 6;
  localparam int PIN2_LSB = 4;
  localparam int PIN1_LSB = 2;
  localparam int PIN0_LSB = 0;
  localparam int PORTD_INTOUT_LSB = 2;
  localparam int PORTE_INTOUT_LSB = 0;
  localparam int PIN15_LSB = 14;
  localparam int PORTD_PIN30_LSB = 12;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Selected function of one pin
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_TIMER,
    FN_DMA,
    FN_INTOUT
  } pin_fn_t;

  // Interrupt-out source selection encoding
  typedef enum logic [1:0] {
    IO_ACK = 2'b00,
    IO_REFRESH = 2'b01,
    IO_MIXED = 2'b10,
    IO_HIGH = 2'b11
  } intout_mode_t;

  // Sources for the interrupt-out pin
  typedef struct packed {
    logic intAck;     // Interrupt request accepted
    logic refresh;    // Refresh signal
    logic refreshNow; // Operation status: refresh cycle in progress
  } intout_src_t;

  // Two-bit field decode shared by pins 0..3
  function automatic pin_fn_t decode2(input logic [1:0] f, input logic singleChip);
    pin_fn_t r;
    r = FN_GPIO;
    if (f == 2'b01) begin
      r = FN_TIMER;
    end else if (f == 2'b10 && !singleChip) begin
      r = FN_DMA;
    end
    return r;
  endfunction

endpackage

// [intout_select.sv]
// Interrupt-out source selector for one pin
`timescale 1ns/1ps
`default_nettype none
module intout_select
  import pin_select_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic enable,
  input wire intout_src_t src,
  output logic pinOut
);

  logic nxtPin;

  // Choose the source by mode; enable gates the whole function
  always_comb begin
    nxtPin = 1'b1;
    if (enable) begin
      case (mode)
        IO_ACK: nxtPin = src.intAck;
        IO_REFRESH: nxtPin = src.refresh;
        IO_MIXED: nxtPin = src.refreshNow ? src.refresh : src.intAck;
        default: nxtPin = 1'b1;
      endcase
    end
  end

  // Registered so the pin never glitches on a mode write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinOut <= 1'b1;
    end else begin
      pinOut <= nxtPin;
    end
  end

  chk_high_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enable && mode == IO_HIGH) |=> pinOut)
    else $error("high mode did not drive high");

endmodule
`default_nettype wire

// [edge_detect.sv]
// Edge detector for a shared request input, seeded low on function switch
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic level,
  output logic edgePulse
);

  logic prev_ff; // Last level seen; held low while the pin is a port
  logic nxt_prev;

  // While inactive the history reads low, so switching onto a high pin counts
  assign nxt_prev = active ? level : 1'b0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign edgePulse = active && level && !prev_ff;

endmodule
`default_nettype wire

// [far_side_model.sv]
// Far-side model: timer, DMA controller, interrupt sources and package pins
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import pin_select_pkg::*;
(
  input wire logic [31:0] rnd,       // Random word, new each cycle
  input wire logic pinHold,          // Outside world holds a steady level
  input wire logic holdLevel,        // That steady level
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  output logic [5:0] timerOut,
  output logic [5:0] timerOe,
  output logic [5:0] gpioOut,
  output logic [5:0] gpioOe,
  output logic dmaCh0Accepted,
  output logic dmaCh1Accepted,
  output intout_src_t intSrc,
  output logic [5:0] pinIn
);
  // Sources wander every cycle so a wrong route shows up quickly
  assign timerOut = rnd[5:0];
  assign timerOe = rnd[11:6];
  assign gpioOut = rnd[17:12];
  // A steady outside world means the port pins are set as inputs
  assign gpioOe = pinHold ? 6'h00 : rnd[23:18];
  assign dmaCh0Accepted = rnd[24];
  assign dmaCh1Accepted = rnd[25];
  assign intSrc = rnd[28:26];
  // Driven pins follow the device; undriven ones follow the outside world
  assign pinIn = (pinOe & pinOut) | (~pinOe & (pinHold ? {6{holdLevel}} : rnd[31:26]));
endmodule
`default_nettype wire

// [port_e_low_pin_select_bench.sv]
// Self-checking bench for the port E low-pin function select block
`timescale 1ns/1ps
`default_nettype none
module port_e_low_pin_select_bench;
  import pin_select_pkg::*;
  logic sys_clk = 0, rst_n = 0, singleChip = 0, package144 = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [5:0] timerOut, timerOe, gpioOut, gpioOe, pinIn, pinOut, pinOe, pinLevel, timerCapture;
  logic dmaCh0Accepted, dmaCh1Accepted, porteIntOutPin, portdIntOutPin;
  logic dmaCh0Request, dmaCh1Request, pinHold = 0, holdLevel = 0, eo, ev;
  intout_src_t intSrc, prevSrc;
  pin_fn_t [5:0] pinFunction;
  pin_fn_t ef;
  logic [31:0] rnd = 32'h1732, d;
  logic [15:0] ctl;
  int mismatches = 0, totalChecks = 0, cycles = 0, pulse0 = 0, pulse1 = 0;

  port_e_low_pin_select u_port_e_low_pin_select (.sys_clk, .rst_n, .singleChip, .package144,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerOut,
    .timerOe, .gpioOut, .gpioOe, .dmaCh0Accepted, .dmaCh1Accepted, .intSrc, .pinIn, .pinOut,
    .pinOe, .porteIntOutPin, .portdIntOutPin, .pinLevel, .timerCapture, .dmaCh0Request,
    .dmaCh1Request, .pinFunction);
  far_side_model u_far_side_model (.rnd, .pinHold, .holdLevel, .pinOut, .pinOe, .timerOut,
    .timerOe, .gpioOut, .gpioOe, .dmaCh0Accepted, .dmaCh1Accepted, .intSrc, .pinIn);

  always #20 sys_clk = ~sys_clk;

  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random word, what the interrupt-out register sampled, pulse counts, hang guard
  always @(posedge sys_clk) begin
    rnd <= lfsrNext(rnd);
    prevSrc <= intSrc;
    pulse0 += (dmaCh0Request === 1'b1);
    pulse1 += (dmaCh1Request === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [3:0] a, input logic [15:0] v);
    logic awDone, wDone;
    awDone = 0;
    wDone = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1;
        s_axi_awvalid <= 0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1;
        s_axi_wvalid <= 0;
      end
    end while (!(awDone && wDone));
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic axiRead(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // Reference decode of one pin's function field
  function automatic pin_fn_t fnOf(input int p, input logic [15:0] c, input logic sc);
    if (p == 4) return c[8] ? FN_TIMER : FN_GPIO;
    if (p == 5) return c[10] ? FN_TIMER : FN_GPIO;
    if (c[2*p +: 2] == 2'b01) return FN_TIMER;
    if (c[2*p +: 2] == 2'b10 && !sc) return FN_DMA;
    return FN_GPIO;
  endfunction

  // Reference interrupt-out level for one mode field
  function automatic logic ioExp(input logic [1:0] m);
    case (m)
      2'b00: return prevSrc.intAck;
      2'b01: return prevSrc.refresh;
      2'b10: return prevSrc.refreshNow ? prevSrc.refresh : prevSrc.intAck;
      default: return 1'b1;
    endcase
  endfunction

  task automatic allCleared();
    for (int i = 0; i < 4; i++) begin
      axiRead(4'(4 * i));
      check("cleared register", d, 0);
    end
  endtask

  task automatic countPulses(input logic [15:0] v, input int e);
    pulse0 = 0;
    pulse1 = 0;
    axiWrite(LOW_CTRL_ADDR, v);
    repeat (8) @(posedge sys_clk);
    check("dma0 pulses", pulse0, e);
    check("dma1 pulses", pulse1, e);
    check("synced levels", pinLevel, 6'h3f);
    check("timer capture", timerCapture, 6'h00);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    allCleared();
    // Reserved bits ignore a deliberate all-ones write
    axiWrite(LOW_CTRL_ADDR, 16'hffff);
    axiRead(LOW_CTRL_ADDR);
    check("low control", d, LOW_CTRL_MASK);
    // Only the low byte lane lands when its strobe alone is set
    s_axi_wstrb <= 4'h1;
    axiWrite(LOW_CTRL_ADDR, 16'h0000);
    s_axi_wstrb <= 4'hf;
    axiRead(LOW_CTRL_ADDR);
    check("byte lane", d, 16'h5500);
    axiWrite(INTOUT_ADDR, 16'hffff);
    axiRead(INTOUT_ADDR);
    check("intout control", d, 16'h000f);
    axiRead(4'h2);
    check("unmapped resp", r, RESP_SLVERR);
    axiWrite(4'h2, 16'hffff);
    check("unmapped write resp", r, RESP_SLVERR);
    axiWrite(INTOUT_ADDR, 16'h0000);
    check("write resp", r, RESP_OKAY);
    // Random function words, random operating mode
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      singleChip <= rnd[3];
      ctl = (rnd[15:0] ^ rnd[31:16]) & 16'hfdff;
      axiWrite(LOW_CTRL_ADDR, ctl);
      @(negedge sys_clk);
      for (int p = 0; p < 6; p++) begin
        ef = fnOf(p, ctl, singleChip);
        eo = (ef == FN_TIMER) ? timerOe[p] : (ef == FN_DMA) ? p[0] : gpioOe[p];
        ev = (ef == FN_TIMER) ? timerOut[p] : (ef == FN_GPIO) ? gpioOut[p] :
             (p == 1) ? dmaCh0Accepted : dmaCh1Accepted;
        check("pin function", pinFunction[p], ef);
        check("pin enable", pinOe[p], eo);
        if (eo) check("pin output", pinOut[p], ev);
      end
    end
    // Interrupt-out selected on both pins, every mode pair
    @(posedge sys_clk);
    singleChip <= 0;
    package144 <= 1;
    axiWrite(HIGH_CTRL_ADDR, 16'hc000);
    axiWrite(PORTD_CTRL_ADDR, 16'h2000);
    for (int m = 0; m < 16; m++) begin
      axiWrite(INTOUT_ADDR, 16'(m));
      repeat (2) @(negedge sys_clk);
      check("upper intout", porteIntOutPin, ioExp(2'(m)));
      check("portd intout", portdIntOutPin, ioExp(2'(m >> 2)));
    end
    // Deselected, wrong package: pins stay high
    @(posedge sys_clk);
    package144 <= 0;
    axiWrite(INTOUT_ADDR, 16'h0000);
    axiWrite(HIGH_CTRL_ADDR, 16'h8000);
    repeat (4) begin
      @(negedge sys_clk);
      check("upper deselected", porteIntOutPin, 1);
      check("portd small pkg", portdIntOutPin, 1);
    end
    // Single chip mode is set before the selection so the pin never leaves high
    @(posedge sys_clk);
    singleChip <= 1;
    axiWrite(HIGH_CTRL_ADDR, 16'hc000);
    repeat (4) begin
      @(negedge sys_clk);
      check("upper single chip", porteIntOutPin, 1);
    end
    // Switching to request function with pins already high catches one edge
    axiWrite(LOW_CTRL_ADDR, 16'h0000);
    singleChip <= 0;
    pinHold <= 1;
    holdLevel <= 1;
    countPulses(16'h0022, 1);
    axiWrite(LOW_CTRL_ADDR, 16'h0000);
    singleChip <= 1;
    countPulses(16'h0022, 0);
    // Power-on reset in mid-run clears everything
    axiWrite(INTOUT_ADDR, 16'h0005);
    @(posedge sys_clk);
    rst_n <= 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    allCleared();
    give_verdict();
  end
endmodule
`default_nettype wire
